// [fsd_pkg.sv]
/*
 package of shared constants for the fieldbus slave diagnosis and indicator
 logic: diagnosis byte layout, station status 1 bit positions, indicator
 pattern codes and timing counts.
 assumes a single 20 MHz clock (mclk) and a synchronous active high reset.
*/
package fsd_pkg;
    // system clock rate and the times derived from it
    localparam int CLK_HZ = 20000000;
    localparam int BLINK_MS = 250;              // flash half period
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int START_MS = 1000;             // start-up flash length
    localparam int START_HALVES = START_MS / BLINK_MS;
    // diagnosis message layout
    localparam int DIAG_LEN = 6;
    localparam logic [2:0] IDX_STAT1 = 3'h0;
    localparam logic [2:0] IDX_STAT2 = 3'h1;
    localparam logic [2:0] IDX_STAT3 = 3'h2;
    localparam logic [2:0] IDX_MADDR = 3'h3;
    localparam logic [2:0] IDX_IDHI = 3'h4;
    localparam logic [2:0] IDX_IDLO = 3'h5;
    // station status 1 bit positions
    localparam int ST1_MASTER_LOCK = 7;
    localparam int ST1_PRM_FAULT = 6;
    localparam int ST1_NO_RESPONSE = 5;
    localparam int ST1_NOT_SUPP = 4;
    localparam int ST1_EXT_DIAG = 3;
    localparam int ST1_CFG_FAULT = 2;
    localparam int ST1_NOT_READY = 1;
    localparam int ST1_ABSENT = 0;
    // station status 2: slave bit always set
    localparam int ST2_SLAVE_BIT = 2;
    // valid station address range
    localparam logic [6:0] ADDR_MIN = 7'h03;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    // reset value of master address byte: none yet
    localparam logic [7:0] MADDR_NONE = 8'hff;
    // identifier default, arbitrary value
    localparam logic [15:0] ID_DEFAULT = 16'h1234;
    // indicator drive codes
    typedef enum logic [1:0] {
        FSD_OFF = 2'b00,
        FSD_ON = 2'b01,
        FSD_BLINK = 2'b10
    } fsd_drive_t;
    // displayed condition
    typedef enum logic [2:0] {
        FSD_START = 3'b000,
        FSD_UV_ON = 3'b001,
        FSD_UV_RUN = 3'b010,
        FSD_HW_FAULT = 3'b011,
        FSD_NO_ADDR = 3'b100,
        FSD_NORMAL = 3'b101
    } fsd_cond_t;
    // address validity check, used by the slave end
    function automatic logic fsd_addr_ok(input logic [6:0] a);
        return (a >= ADDR_MIN) && (a <= ADDR_MAX);
    endfunction
endpackage

// [fsd_link_if.sv]
/*
 interface joining the slave diagnosis end and the master end.
 assumes both ends run on the same clock; a request pulse from the
 master is answered by six bytes, one per cycle, from the slave.
*/
`timescale 1ns/10ps
interface fsd_link_if;
    logic diagReq;      // master asks for diagnosis, one-cycle pulse
    logic diagValid;    // slave byte valid
    logic [7:0] diagByte; // diagnosis byte
    logic diagLast;     // marks byte 6
    logic prmValid;     // master sends parameterization, pulse
    logic [6:0] prmMaster; // address of that master
    logic prmGood;      // parameterization acceptable
    logic cfgValid;     // master sends configuration, pulse
    logic cfgGood;      // configuration acceptable
    logic funcReq;      // master requests a function, pulse
    logic funcSupported; // function known to slave
    modport slave(input diagReq, prmValid, prmMaster, prmGood, cfgValid,
        cfgGood, funcReq, funcSupported,
        output diagValid, diagByte, diagLast);
    modport master(output diagReq, prmValid, prmMaster, prmGood, cfgValid,
        cfgGood, funcReq, funcSupported,
        input diagValid, diagByte, diagLast);
endinterface

// [fsd_blinker.sv]
/*
 flash timebase: a one-cycle enable every half period and a toggling phase.
 assumes mclk at the package rate.
*/
`timescale 1ns/10ps
module fsd_blinker
    import fsd_pkg::*;
#(
    parameter int HALF_CYC = BLINK_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    output logic tick,
    output logic phase
);
    logic [31:0] cnt_q; // cycles within a half period

    // divider: slower rate as enable pulse
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_q == 32'(HALF_CYC - 1)) begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
        end
    end

    // phase flips on each tick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase <= 1'b0;
        end else if (tick) begin
            phase <= ~phase;
        end
    end
endmodule

// [fsd_slave.sv]
/*
 slave end: indicator drive and standard diagnosis responder.
 assumes supply monitor, address switch and application flags are
 synchronous level inputs; the master end sits on the link interface.
*/
`timescale 1ns/10ps
module fsd_slave
    import fsd_pkg::*;
#(
    parameter int HALF_CYC = BLINK_CYC,
    parameter logic [15:0] IDENT = ID_DEFAULT // arbitrary value
) (
    input wire logic mclk,
    input wire logic sys_rst,
    fsd_link_if.slave link,
    input wire logic underVolt,
    input wire logic hwFault,
    input wire logic [6:0] stationAddr,
    input wire logic linkActive,
    input wire logic extDiagAvail,
    input wire logic dataReady,
    output logic ledErr,
    output logic ledOk,
    output logic ledRun
);
    logic tick; // one-cycle enable per flash half period
    logic phase; // shared flash phase, keeps all blinking lamps in step
    logic [3:0] halves_q;       // start-up flash progress
    logic started_q;            // start-up flash done
    logic uvOn_q;               // under-voltage seen at switch-on
    logic uvRun_q;              // under-voltage during operation
    logic prmFault_q;           // last parameterization refused
    logic notSupp_q;            // last function request unknown
    logic cfgFault_q;           // last configuration refused
    logic haveMaster_q;         // a good parameterization was seen
    logic [7:0] mAddr_q;        // first valid master address
    logic [2:0] idx_q;          // diagnosis byte being sent
    logic busy_q;               // diagnosis burst in progress
    fsd_cond_t cond;            // condition shown on the lamps
    fsd_drive_t dErr;           // drive code of the red fault lamp
    fsd_drive_t dOk;            // drive code of the green ok lamp
    fsd_drive_t dRun;           // drive code of the green run lamp

    // drive code to lamp state; one decode shared by all three lamps
    function automatic logic lamp(input fsd_drive_t d, input logic ph);
        return (d == FSD_ON) || (d == FSD_BLINK && ph);
    endfunction

    fsd_blinker #(.HALF_CYC(HALF_CYC)) uBlink (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick),
        .phase(phase)
    );

    // start-up flash period counted in half periods
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            halves_q <= 4'h0;
            started_q <= 1'b0;
        end else if (!started_q && tick) begin
            halves_q <= halves_q + 4'h1;
            if (halves_q == 4'(START_HALVES - 1))
                started_q <= 1'b1;
        end
    end

    // under-voltage: during start-up counts as switch-on, later as running
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            uvOn_q <= 1'b0;
            uvRun_q <= 1'b0;
        end else if (underVolt) begin
            if (!started_q)
                uvOn_q <= 1'b1;
            else
                uvRun_q <= 1'b1;
        end
    end

    // condition priority: start-up, under-voltage, hardware, link, normal
    always_comb begin
        if (!started_q)
            cond = FSD_START;
        else if (uvOn_q)
            cond = FSD_UV_ON;
        else if (uvRun_q)
            cond = FSD_UV_RUN;
        else if (hwFault || !fsd_addr_ok(stationAddr))
            cond = FSD_HW_FAULT;
        else if (!linkActive)
            cond = FSD_NO_ADDR;
        else
            cond = FSD_NORMAL;
    end

    // fixed pattern table, each condition distinct
    always_comb begin
        unique case (cond)
            FSD_START: begin
                dErr = FSD_BLINK;
                dOk = FSD_BLINK;
                dRun = FSD_BLINK;
            end
            FSD_UV_ON: begin
                dErr = FSD_OFF;
                dOk = FSD_BLINK;
                dRun = FSD_OFF;
            end
            FSD_UV_RUN: begin
                dErr = FSD_OFF;
                dOk = FSD_OFF;
                dRun = FSD_OFF;
            end
            FSD_HW_FAULT: begin
                dErr = FSD_ON;
                dOk = FSD_OFF;
                dRun = FSD_OFF;
            end
            FSD_NO_ADDR: begin
                dErr = FSD_ON;
                dOk = FSD_ON;
                dRun = FSD_OFF;
            end
            FSD_NORMAL: begin
                dErr = FSD_OFF;
                dOk = FSD_ON;
                dRun = FSD_ON;
            end
            // unused codes show a fault rather than a lamp test
            default: begin
                dErr = FSD_ON;
                dOk = FSD_OFF;
                dRun = FSD_OFF;
            end
        endcase
    end

    // indicator outputs registered; blink follows the shared phase
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ledErr <= 1'b0;
            ledOk <= 1'b0;
            ledRun <= 1'b0;
        end else begin
            ledErr <= lamp(dErr, phase);
            ledOk <= lamp(dOk, phase);
            ledRun <= lamp(dRun, phase);
        end
    end

    // slave-set status flags reflect the most recent message of each kind
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prmFault_q <= 1'b0;
            cfgFault_q <= 1'b0;
            notSupp_q <= 1'b0;
        end else begin
            if (link.prmValid)
                prmFault_q <= !link.prmGood;
            if (link.cfgValid)
                cfgFault_q <= !link.cfgGood;
            if (link.funcReq)
                notSupp_q <= !link.funcSupported;
        end
    end

    // first master with a valid parameterization is latched
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            haveMaster_q <= 1'b0;
            mAddr_q <= MADDR_NONE;
        end else if (link.prmValid && link.prmGood && !haveMaster_q) begin
            haveMaster_q <= 1'b1;
            mAddr_q <= {1'b0, link.prmMaster};
        end
    end

    // station status 1 as seen by the slave; master bits left clear
    function automatic logic [7:0] stat1();
        logic [7:0] s;
        s = 8'h00;
        s[ST1_PRM_FAULT] = prmFault_q;
        s[ST1_NOT_SUPP] = notSupp_q;
        s[ST1_EXT_DIAG] = extDiagAvail;
        s[ST1_CFG_FAULT] = cfgFault_q;
        s[ST1_NOT_READY] = !dataReady || !haveMaster_q;
        return s;
    endfunction

    // diagnosis responder: request pulse answered by six bytes in order
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            idx_q <= IDX_STAT1;
            link.diagValid <= 1'b0;
            link.diagByte <= 8'h00;
            link.diagLast <= 1'b0;
        end else begin
            if (!busy_q && link.diagReq) begin
                busy_q <= 1'b1;
                idx_q <= IDX_STAT1;
            end else if (busy_q) begin
                idx_q <= idx_q + 3'h1;
                if (idx_q == IDX_IDLO)
                    busy_q <= 1'b0;
            end
            link.diagValid <= busy_q;
            link.diagLast <= busy_q && idx_q == IDX_IDLO;
            unique case (idx_q)
                IDX_STAT1: link.diagByte <= stat1();
                IDX_STAT2: link.diagByte <= 8'h01 << ST2_SLAVE_BIT;
                IDX_STAT3: link.diagByte <= 8'h00;
                IDX_MADDR: link.diagByte <= mAddr_q;
                IDX_IDHI: link.diagByte <= IDENT[15:8];
                IDX_IDLO: link.diagByte <= IDENT[7:0];
                default: link.diagByte <= 8'h00;
            endcase
        end
    end
endmodule

// [fsd_master.sv]
/*
 master end: polls slave diagnosis, merges its own station status 1
 bits and reports the six bytes to the host side.
 assumes the slave answers on the link interface within a bounded time.
*/
`timescale 1ns/10ps
module fsd_master
    import fsd_pkg::*;
#(
    parameter int TIMEOUT = 16 // cycles to wait for first byte
) (
    input wire logic mclk,
    input wire logic sys_rst,
    fsd_link_if.master link,
    input wire logic pollReq,       // host asks for a diagnosis
    input wire logic configured,    // slave is in the master's list
    input wire logic lockedByOther, // slave owned by another master
    input wire logic sendPrm,
    input wire logic [6:0] ownAddr,
    input wire logic prmOk,
    input wire logic sendCfg,
    input wire logic cfgOk,
    input wire logic sendFunc,
    input wire logic funcOk,
    output logic [47:0] diagOut,    // byte 1 in top bits
    output logic diagDone
);
    logic waiting_q, got_q;
    logic [7:0] tmo_q;
    logic [2:0] cnt_q;

    // forward host requests to the link as registered copies; diagReq gated while waiting
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link.diagReq <= 1'b0;
            link.prmValid <= 1'b0;
            link.prmMaster <= 7'h00;
            link.prmGood <= 1'b0;
            link.cfgValid <= 1'b0;
            link.cfgGood <= 1'b0;
            link.funcReq <= 1'b0;
            link.funcSupported <= 1'b0;
        end else begin
            link.diagReq <= pollReq && !waiting_q;
            link.prmValid <= sendPrm;
            link.prmMaster <= ownAddr;
            link.prmGood <= prmOk;
            link.cfgValid <= sendCfg;
            link.cfgGood <= cfgOk;
            link.funcReq <= sendFunc;
            link.funcSupported <= funcOk;
        end
    end

    // collect bytes; on silence, report no response, with the absence bit copied from configured
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            waiting_q <= 1'b0;
            got_q <= 1'b0;
            tmo_q <= 8'h00;
            cnt_q <= 3'h0;
            diagOut <= 48'h0;
            diagDone <= 1'b0;
        end else begin
            diagDone <= 1'b0;
            if (link.diagReq) begin
                waiting_q <= 1'b1;
                got_q <= 1'b0;
                tmo_q <= 8'h00;
                cnt_q <= 3'h0;
            end else if (waiting_q && link.diagValid) begin
                got_q <= 1'b1;
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == IDX_STAT1) begin
                    diagOut <= {diagOut[39:0], link.diagByte |
                        (8'(lockedByOther) << ST1_MASTER_LOCK)};
                end else begin
                    diagOut <= {diagOut[39:0], link.diagByte};
                end
                if (link.diagLast) begin
                    waiting_q <= 1'b0;
                    diagDone <= 1'b1;
                end
            end else if (waiting_q && !got_q) begin
                tmo_q <= tmo_q + 8'h01;
                if (tmo_q == 8'(TIMEOUT - 1)) begin
                    waiting_q <= 1'b0;
                    diagDone <= 1'b1;
                    diagOut <= {(8'h01 << ST1_NO_RESPONSE) |
                        (8'(configured) << ST1_ABSENT), 40'h0};
                end
            end
        end
    end
endmodule

// [fsd_link_asserts.sv]
/*
 checker for the diagnosis link between slave and master ends.
 assumes one clock, synchronous active high reset, and that no
 prm, cfg or func message is sent while a diagnosis is in flight.
*/
`timescale 1ns/10ps
module fsd_link_asserts
    import fsd_pkg::*;
#(
    parameter logic [15:0] IDENT = ID_DEFAULT
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic diagReq,
    input wire logic diagValid,
    input wire logic [7:0] diagByte,
    input wire logic diagLast,
    input wire logic prmValid,
    input wire logic [6:0] prmMaster,
    input wire logic prmGood,
    input wire logic cfgValid,
    input wire logic cfgGood,
    input wire logic funcReq,
    input wire logic funcSupported
);
    logic prmBad_q; // last prm refused
    logic cfgBad_q; // last cfg refused
    logic funcBad_q; // last function unknown
    logic [7:0] firstM_q; // first good master, ff while none

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // shadow of last-message flags, updated as each message passes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prmBad_q <= 1'b0;
            cfgBad_q <= 1'b0;
            funcBad_q <= 1'b0;
        end else begin
            if (prmValid) prmBad_q <= !prmGood;
            if (cfgValid) cfgBad_q <= !cfgGood;
            if (funcReq) funcBad_q <= !funcSupported;
        end
    end

    // only the first good master is kept, later ones leave it alone
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            firstM_q <= 8'hff;
        end else if (prmValid && prmGood && firstM_q == 8'hff) begin
            firstM_q <= {1'b0, prmMaster};
        end
    end

    a_answer_window: assert property (diagReq |-> ##1 !diagValid ##1
        diagValid [*6] ##1 !diagValid) else $error("diag burst shape bad");
    a_last_sixth: assert property (diagReq |-> ##7 diagLast)
        else $error("diagLast not on sixth byte");
    a_last_in_burst: assert property (diagLast |->
        diagValid && $past(diagValid, 5)) else $error("stray diagLast");
    a_stat_fixed: assert property (diagReq |-> ##3 diagByte == 8'h04
        ##1 diagByte == 8'h00) else $error("status 2 or 3 wrong");
    a_ident_bytes: assert property (diagLast |->
        diagByte == IDENT[7:0] && $past(diagByte) == IDENT[15:8])
        else $error("identifier bytes wrong");
    a_master_addr: assert property (diagReq |->
        ##5 diagByte == firstM_q) else $error("master address wrong");
    a_slave_flags: assert property (diagReq |-> ##2
        (diagByte[6] == prmBad_q && diagByte[4] == funcBad_q &&
        diagByte[2] == cfgBad_q)) else $error("slave flags wrong");
    a_master_bits: assert property (diagReq |-> ##2
        (!diagByte[7] && !diagByte[5] && !diagByte[0]))
        else $error("slave drove master bits");
    a_not_ready: assert property (diagReq |-> ##2
        (firstM_q != 8'hff || diagByte[1])) else $error("ready too early");
endmodule

// [fieldbus_slave_diag_leds_bench.sv]
/*
 testbench: slave and master ends face each other on one link, and a
 second master faces a silent far end to force its timeout.
 assumes HALF_CYC of 4 so start-up flashing lasts 16 cycles.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("mismatch at %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module fieldbus_slave_diag_leds_bench
    import fsd_pkg::*;
;
    localparam logic [15:0] IDV = 16'hbeef; // arbitrary value
    localparam int TMO = 16;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic underVolt = 0, hwFault = 0, linkActive = 0, extDiagAvail = 0;
    logic dataReady = 1, pollReq = 0, configured = 0, lockedByOther = 0;
    logic sendPrm = 0, prmOk = 0, sendCfg = 0, cfgOk = 0;
    logic sendFunc = 0, funcOk = 0;
    logic [6:0] stationAddr = 7'h0a, ownAddr = 7'h05;
    logic ledErr, ledOk, ledRun, diagDone, diagDoneB, orOk, andOk;
    logic [47:0] diagOut, diagOutB, gotA, gotB;
    logic [7:0] firstM = 8'hff; // model of first good master
    logic [31:0] r;
    int bad_count = 0;
    int total_checks = 0;
    int seed = 32'hcfb9ad2a;

    fsd_link_if link();
    fsd_link_if link2(); // far end that never answers
    fsd_slave #(.HALF_CYC(4), .IDENT(IDV)) i_fsd_slave(.mclk(mclk),
        .sys_rst(sys_rst), .link(link), .underVolt(underVolt),
        .hwFault(hwFault), .stationAddr(stationAddr),
        .linkActive(linkActive), .extDiagAvail(extDiagAvail),
        .dataReady(dataReady), .ledErr(ledErr), .ledOk(ledOk),
        .ledRun(ledRun));
    fsd_master #(.TIMEOUT(TMO)) i_fsd_master(.mclk(mclk), .sys_rst(sys_rst),
        .link(link), .pollReq(pollReq), .configured(configured),
        .lockedByOther(lockedByOther), .sendPrm(sendPrm), .ownAddr(ownAddr),
        .prmOk(prmOk), .sendCfg(sendCfg), .cfgOk(cfgOk),
        .sendFunc(sendFunc), .funcOk(funcOk), .diagOut(diagOut),
        .diagDone(diagDone));
    fsd_master #(.TIMEOUT(TMO)) i_fsd_master_b(.mclk(mclk),
        .sys_rst(sys_rst), .link(link2), .pollReq(pollReq),
        .configured(configured), .lockedByOther(lockedByOther),
        .sendPrm(sendPrm), .ownAddr(ownAddr), .prmOk(prmOk),
        .sendCfg(sendCfg), .cfgOk(cfgOk), .sendFunc(sendFunc),
        .funcOk(funcOk), .diagOut(diagOutB), .diagDone(diagDoneB));
    fsd_link_asserts #(.IDENT(IDV)) i_fsd_link_asserts(.mclk(mclk),
        .sys_rst(sys_rst), .diagReq(link.diagReq),
        .diagValid(link.diagValid), .diagByte(link.diagByte),
        .diagLast(link.diagLast), .prmValid(link.prmValid),
        .prmMaster(link.prmMaster), .prmGood(link.prmGood),
        .cfgValid(link.cfgValid), .cfgGood(link.cfgGood),
        .funcReq(link.funcReq), .funcSupported(link.funcSupported));

    // 20 MHz clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    // silent far end: no valid, data line keeps changing, never stale;
    // one process owns all three so each has a single driver
    initial begin
        link2.diagValid = 1'b0;
        link2.diagLast = 1'b0;
        link2.diagByte = 8'h5a;
        forever begin
            @(posedge mclk);
            link2.diagByte <= ~link2.diagByte;
        end
    end

    // expected six bytes, worked out from the stimulus
    function automatic logic [47:0] expDiag(input logic [7:0] fm);
        logic [7:0] s1;
        s1 = {lockedByOther, !prmOk, 1'b0, !funcOk, extDiagAvail, !cfgOk,
            !dataReady || fm == 8'hff, 1'b0};
        return {s1, 8'h04, 8'h00, fm, IDV};
    endfunction

    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task do_reset;
        sys_rst = 1'b1;
        cyc(16);
        sys_rst = 1'b0;
    endtask

    // pattern settles one cycle after its cause, two for under-voltage; leave margin
    task led_is(input logic [2:0] e);
        cyc(3);
        `CHK({ledErr, ledOk, ledRun}, e)
    endtask

    // one poll; both masters report within the window or fail
    task poll;
        pollReq = 1'b1;
        cyc(1);
        pollReq = 1'b0;
        gotA = '0;
        gotB = '0;
        repeat (TMO + 20) begin
            cyc(1);
            if (diagDone === 1'b1) gotA = diagOut;
            if (diagDoneB === 1'b1) gotB = diagOutB;
        end
    endtask

    task print_verdict;
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog, far above the expected run length
    initial begin
        #(50 * 20000);
        bad_count++;
        print_verdict;
    end

    // main sequence
    initial begin
        #1;
        do_reset;
        orOk = 1'b0;
        andOk = 1'b1;
        repeat (14) begin
            cyc(1);
            orOk = orOk | ledErr;
            andOk = andOk & ledErr;
            `CHK({ledOk, ledRun}, {ledErr, ledErr})
        end
        `CHK({orOk, andOk}, 2'b10)
        cyc(6);
        led_is(3'b110);
        linkActive = 1'b1;
        led_is(3'b011);
        for (int i = 0; i < 6; i++) begin
            stationAddr = i[0] ? {i[1], 6'h3f} : 7'(i + 1);
            led_is((stationAddr >= 3 && stationAddr <= 99) ? 3'b011
                : 3'b100);
        end
        stationAddr = 7'h63;
        led_is(3'b011);
        hwFault = 1'b1;
        led_is(3'b100);
        hwFault = 1'b0;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            {lockedByOther, prmOk, cfgOk, funcOk} = r[3:0];
            {extDiagAvail, dataReady, configured} = r[6:4];
            ownAddr = r[14:8];
            if (i < 2) prmOk = i[0];
            if (prmOk && firstM == 8'hff) firstM = {1'b0, ownAddr};
            sendPrm = 1'b1;
            cyc(1);
            sendPrm = 1'b0;
            cyc(4);
            sendCfg = 1'b1;
            cyc(1);
            sendCfg = 1'b0;
            cyc(4);
            sendFunc = 1'b1;
            cyc(1);
            sendFunc = 1'b0;
            cyc(6);
            poll;
            `CHK(gotA, expDiag(firstM))
            `CHK(gotB, {7'h10, configured, 40'h0})
        end
        underVolt = 1'b1;
        led_is(3'b000);
        underVolt = 1'b0;
        led_is(3'b000);
        underVolt = 1'b1;
        do_reset;
        cyc(24);
        orOk = 1'b0;
        andOk = 1'b1;
        repeat (12) begin
            cyc(1);
            orOk = orOk | ledOk;
            andOk = andOk & ledOk;
            `CHK({ledErr, ledRun}, 2'b00)
        end
        `CHK({orOk, andOk}, 2'b10)
        print_verdict;
    end
endmodule
